// ### verilog/pscl_pkg.sv
// Constants and types shared by the passive serial configuration loader.
package pscl_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int POR_TIME_NS = 45000;
	localparam int POR_CYCLES_DEF = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_TIME_NS = 300000;
	localparam int INIT_CYCLES_DEF = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	localparam int IMAGE_BYTES = 16;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] LAST_ADDR = 4'hf;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [1:0] FALL_EDGES = 2'h2;
	localparam logic [7:0] CHECK_OK = 8'h00;

	typedef enum logic [2:0] {
		PSCL_POR = 3'b000,
		PSCL_RESET = 3'b001,
		PSCL_LOAD = 3'b010,
		PSCL_DONE = 3'b011,
		PSCL_INIT = 3'b100,
		PSCL_USER = 3'b101,
		PSCL_ERROR = 3'b110
	} pscl_state_t;

endpackage

// ### verilog/pscl_image_mem.sv
// Small image store for the loaded configuration bytes, registered read port.
`timescale 1ns/1ns
module pscl_image_mem (
	input wire logic clock,
	input wire logic wr_en,
	input wire logic [pscl_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [pscl_pkg::ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data
);
	import pscl_pkg::*;

	logic [7:0] mem [IMAGE_BYTES];

	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule

// ### verilog/pscl_loader.sv
// Passive serial configuration loader as it sits inside the configured device.
`timescale 1ns/1ns
module pscl_loader #(
	parameter int POR_CYCLES = pscl_pkg::POR_CYCLES_DEF,
	parameter int INIT_CYCLES = pscl_pkg::INIT_CYCLES_DEF
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic config_request_n,
	input wire logic serial_config_clock,
	input wire logic serial_config_data,
	input wire logic chain_enable_in_n,
	input wire logic config_status_n_in,
	output logic config_status_n_out,
	output logic config_status_n_oe,
	input wire logic config_complete_in,
	output logic config_complete_out,
	output logic config_complete_oe,
	output logic init_complete_out,
	output logic init_complete_oe,
	output logic chain_enable_out_n,
	output logic user_mode,
	output logic weak_pullup_en,
	input wire logic user_data_pin_en,
	input wire logic user_data_out,
	output logic data_pin_out,
	output logic data_pin_oe,
	input wire logic [pscl_pkg::ADDR_W-1:0] image_rd_addr,
	output logic [7:0] image_rd_data
);
	import pscl_pkg::*;

	typedef struct packed {
		pscl_state_t st;
		logic req_s1;
		logic req_s2;
		logic clk_s1;
		logic clk_s2;
		logic clk_d;
		logic dat_s1;
		logic dat_s2;
		logic ce_s1;
		logic ce_s2;
		logic sts_s1;
		logic sts_s2;
		logic cd_s1;
		logic cd_s2;
		logic [CNT_W-1:0] cnt;
		logic [7:0] shift;
		logic [2:0] bitc;
		logic [ADDR_W-1:0] addr;
		logic [7:0] chk;
		logic [1:0] falls;
		logic wr_en;
		logic [ADDR_W-1:0] wr_addr;
		logic [7:0] wr_data;
		logic dout;
		logic armed;
	} pscl_regs_t;

	pscl_regs_t r_r;
	pscl_regs_t r_nxt;
	logic rise;
	logic fall;
	logic [7:0] byte_in;

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	assign rise = r_r.clk_s2 & ~r_r.clk_d;
	assign fall = ~r_r.clk_s2 & r_r.clk_d;
	assign byte_in = {r_r.dat_s2, r_r.shift[7:1]};

	always_comb begin
		r_nxt = r_r;
		r_nxt.req_s1 = config_request_n;
		r_nxt.req_s2 = r_r.req_s1;
		r_nxt.clk_s1 = serial_config_clock;
		r_nxt.clk_s2 = r_r.clk_s1;
		r_nxt.clk_d = r_r.clk_s2;
		r_nxt.dat_s1 = serial_config_data;
		r_nxt.dat_s2 = r_r.dat_s1;
		r_nxt.ce_s1 = chain_enable_in_n;
		r_nxt.ce_s2 = r_r.ce_s1;
		r_nxt.sts_s1 = config_status_n_in;
		r_nxt.sts_s2 = r_r.sts_s1;
		r_nxt.cd_s1 = config_complete_in;
		r_nxt.cd_s2 = r_r.cd_s1;
		r_nxt.wr_en = 1'b0;
		r_nxt.dout = user_data_out;
		unique case (r_r.st)
			PSCL_POR: begin
				r_nxt.cnt = r_r.cnt + 1'b1;
				if (r_r.cnt == CNT_W'(POR_CYCLES - 1)) begin
					r_nxt.st = PSCL_RESET;
				end
			end
			PSCL_RESET: begin
				r_nxt.cnt = '0;
				r_nxt.bitc = '0;
				r_nxt.addr = '0;
				r_nxt.chk = '0;
				r_nxt.falls = '0;
				r_nxt.armed = 1'b0;
				if (r_r.req_s2) begin
					r_nxt.st = PSCL_LOAD;
				end
			end
			PSCL_LOAD: begin
				// Our own status pull needs two clocks to leave the synchroniser, so a low
				// status only counts as an error once the line has been seen high in this load.
				if (!r_r.armed) begin
					r_nxt.armed = r_r.sts_s2;
				// another chain member flagged an error
				end else if (!r_r.sts_s2) begin
					r_nxt.st = PSCL_ERROR;
				end else if (!r_r.ce_s2 && rise) begin
					r_nxt.shift = byte_in;
					r_nxt.bitc = r_r.bitc + 1'b1;
					if (r_r.bitc == LAST_BIT) begin
						r_nxt.wr_en = 1'b1;
						r_nxt.wr_addr = r_r.addr;
						r_nxt.wr_data = byte_in;
						r_nxt.chk = r_r.chk ^ byte_in;
						r_nxt.addr = r_r.addr + 1'b1;
						if (r_r.addr == LAST_ADDR) begin
							// image check decides done or error
							r_nxt.st = ((r_r.chk ^ byte_in) == CHECK_OK) ? PSCL_DONE : PSCL_ERROR;
						end
					end
				end
			end
			PSCL_DONE: begin
				// count falling edges once the shared line is high
				if (!r_r.sts_s2) begin
					r_nxt.st = PSCL_ERROR;
				end else if (r_r.falls == FALL_EDGES) begin
					r_nxt.st = PSCL_INIT;
					r_nxt.cnt = '0;
				end else if (fall && r_r.cd_s2) begin
					r_nxt.falls = r_r.falls + 1'b1;
				end
			end
			PSCL_INIT: begin
				r_nxt.cnt = r_r.cnt + 1'b1;
				// release init complete at the end
				if (r_r.cnt == CNT_W'(INIT_CYCLES - 1)) begin
					r_nxt.st = PSCL_USER;
				end
			end
			PSCL_USER: begin
				r_nxt.cnt = '0;
			end
			PSCL_ERROR: begin
				r_nxt.cnt = '0;
			end
			default: begin
				r_nxt.st = PSCL_RESET;
			end
		endcase
		// a low request restarts from any state past power-on
		if (!r_r.req_s2 && r_r.st != PSCL_POR) begin
			r_nxt.st = PSCL_RESET;
		end
	end

	// there is no timeout, so a halted serial clock simply holds the shift, bit count, address and check fields.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pins.

	// status held low in power-on, reset and error
	assign config_status_n_out = 1'b0;
	assign config_status_n_oe = (r_r.st == PSCL_POR) || (r_r.st == PSCL_RESET) || (r_r.st == PSCL_ERROR);
	// complete released once own image is in
	assign config_complete_out = 1'b0;
	assign config_complete_oe = (r_r.st == PSCL_POR) || (r_r.st == PSCL_RESET) || (r_r.st == PSCL_LOAD) ||
		(r_r.st == PSCL_ERROR);
	// init complete low until user mode
	assign init_complete_out = 1'b0;
	assign init_complete_oe = (r_r.st != PSCL_USER);
	// enable the next device after our image
	assign chain_enable_out_n = !((r_r.st == PSCL_DONE) || (r_r.st == PSCL_INIT) || (r_r.st == PSCL_USER));
	assign user_mode = (r_r.st == PSCL_USER);
	assign weak_pullup_en = (r_r.st != PSCL_USER);
	// data pin tri-stated unless the user option claims it in user mode
	assign data_pin_out = r_r.dout;
	assign data_pin_oe = user_mode && user_data_pin_en;

	pscl_image_mem u_mem (
		.clock(clock),
		.wr_en(r_r.wr_en),
		.wr_addr(r_r.wr_addr),
		.wr_data(r_r.wr_data),
		.rd_addr(image_rd_addr),
		.rd_data(image_rd_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	status_por_low_a: assert property (r_r.st == PSCL_POR |-> config_status_n_oe)
		else $error("status not held low during power-on delay");
	complete_load_low_a: assert property (r_r.st == PSCL_LOAD |-> config_complete_oe)
		else $error("complete released during load");
	init_held_low_a: assert property (r_r.st != PSCL_USER |-> init_complete_oe)
		else $error("init complete released before user mode");
	bit_sample_a: assert property (r_r.st == PSCL_LOAD && r_r.armed && r_r.sts_s2 && r_r.req_s2 && !r_r.ce_s2 && rise
		|=> r_r.bitc == $past(r_r.bitc) + 3'h1)
		else $error("rising serial clock edge did not take a bit");
	chain_ignore_a: assert property (r_r.st == PSCL_LOAD && r_r.ce_s2 |=> r_r.bitc == $past(r_r.bitc))
		else $error("bit taken while chain enable was high");
	done_stops_a: assert property (r_r.st == PSCL_DONE |=> r_r.bitc == $past(r_r.bitc))
		else $error("bit taken after load finished");
	chain_out_a: assert property (r_r.st == PSCL_LOAD ##1 r_r.st == PSCL_DONE |-> !chain_enable_out_n)
		else $error("chain enable out not driven after own image");
	init_gate_a: assert property (r_r.st == PSCL_DONE ##1 r_r.st == PSCL_INIT
		|-> $past(r_r.falls) == FALL_EDGES && $past(r_r.cd_s2, 2))
		else $error("initialization began too early");
	user_entry_a: assert property (r_r.st == PSCL_INIT && r_r.req_s2 && r_r.cnt == CNT_W'(INIT_CYCLES - 1)
		|=> user_mode && !init_complete_oe && !weak_pullup_en)
		else $error("user mode not entered at end of initialization");
	abort_user_a: assert property (r_r.st == PSCL_USER && !r_r.req_s2 |=> r_r.st == PSCL_RESET ##1 !user_mode)
		else $error("low request did not abort user mode");
	error_status_a: assert property (r_r.st == PSCL_LOAD && r_r.armed && !r_r.sts_s2 && r_r.req_s2
		|=> config_status_n_oe)
		else $error("error did not pull status low");
	data_tristate_a: assert property (!user_data_pin_en |-> !data_pin_oe)
		else $error("data pin driven without the user option");

endmodule

// ### bench/pscl_host.sv
// Host model that starts configuration and shifts an image into the loader.
`timescale 1ns/1ns
module pscl_host (
	input wire logic clock,
	input wire logic config_status_n,
	output logic config_request_n,
	output logic serial_config_clock,
	output logic serial_config_data
);
	initial begin
		config_request_n = 1'b0;
		serial_config_clock = 1'b0;
		serial_config_data = 1'b0;
	end
	// one link period
	// The link clock rests low between bits, so a pause simply stretches the low phase.
	task link_pulse();
		repeat (4) @(negedge clock);
		serial_config_clock = 1'b1;
		repeat (4) @(negedge clock);
		serial_config_clock = 1'b0;
	endtask
	task start(output bit ok);
		config_request_n = 1'b0;
		repeat (60) @(negedge clock);
		config_request_n = 1'b1;
		ok = 0;
		for (int i = 0; i < 100 && !ok; i++) begin
			@(negedge clock);
			ok = (config_status_n === 1'b1);
		end
		repeat (2) @(negedge clock);
	endtask
	task send_image(input logic [127:0] img, input bit pause);
		for (int n = 0; n < 128; n++) begin
			@(negedge clock);
			serial_config_data = img[n];
			link_pulse();
			if (pause && n == 60) repeat (300) @(negedge clock);
		end
	endtask
	task finish();
		link_pulse();
		link_pulse();
	endtask
endmodule

// ### bench/tb.sv
// Self-checking bench for the passive serial configuration loader.
`timescale 1ns/1ns
module tb;
	import pscl_pkg::*;
	localparam int INIT_N = 30;
	logic clock, rst_b, chain_enable_in_n, user_data_pin_en, user_data_out;
	logic status_oe, status_out, complete_oe, complete_out, init_oe, init_out;
	logic chain_enable_out_n, user_mode, weak_pullup_en, pin_out, pin_oe;
	logic req_n, sclk, sdata, ext_status_low;
	logic [ADDR_W-1:0] rd_addr;
	logic [7:0] rd_data;
	int failures, n_tests;
	bit ok;
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	pscl_loader #(.POR_CYCLES(20), .INIT_CYCLES(INIT_N)) dut (.clock(clock), .rst_b(rst_b),
		.config_request_n(req_n), .serial_config_clock(sclk), .serial_config_data(sdata),
		.chain_enable_in_n(chain_enable_in_n), .config_status_n_in(!status_oe && !ext_status_low),
		.config_status_n_out(status_out), .config_status_n_oe(status_oe),
		.config_complete_in(!complete_oe), .config_complete_out(complete_out),
		.config_complete_oe(complete_oe), .init_complete_out(init_out), .init_complete_oe(init_oe),
		.chain_enable_out_n(chain_enable_out_n), .user_mode(user_mode), .weak_pullup_en(weak_pullup_en),
		.user_data_pin_en(user_data_pin_en), .user_data_out(user_data_out), .data_pin_out(pin_out),
		.data_pin_oe(pin_oe), .image_rd_addr(rd_addr), .image_rd_data(rd_data));
	pscl_host host (.clock(clock), .config_status_n(!status_oe && !ext_status_low), .config_request_n(req_n),
		.serial_config_clock(sclk), .serial_config_data(sdata));
	////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask
	// The last byte makes the XOR of the image zero; bad flips its low bit.
	function automatic logic [127:0] make_img(input logic [7:0] seed, input bit bad);
		logic [7:0] x;
		x = 8'h00;
		for (int n = 0; n < 15; n++) begin
			make_img[n*8+:8] = seed + 8'(n * 37);
			x ^= make_img[n*8+:8];
		end
		make_img[127:120] = x ^ {7'h00, bad};
	endfunction
	task load(input logic [127:0] img, input bit pause);
		host.start(ok);
		chk("status released", 8'h01, 8'(ok));
		host.send_image(img, pause);
		for (int i = 0; i < 20 && complete_oe !== 1'b0; i++) @(negedge clock);
	endtask
	task t_ignore();
		chain_enable_in_n = 1'b1;
		load(make_img(8'h11, 0), 0);
		chk("complete held", 8'h01, 8'(complete_oe));
		chk("chain out held", 8'h01, 8'(chain_enable_out_n));
		chain_enable_in_n = 1'b0;
		$display("t_ignore done");
	endtask
	task t_good(input bit opt);
		logic [127:0] img;
		img = make_img(8'h5a, 0);
		user_data_pin_en = opt;
		user_data_out = 1'b1;
		load(img, !opt);
		chk("complete_oe", 8'h00, 8'(complete_oe));
		chk("chain out", 8'h00, 8'(chain_enable_out_n));
		repeat (INIT_N + 10) @(negedge clock);
		chk("user_mode early", 8'h00, 8'(user_mode));
		chk("init_oe early", 8'h01, 8'(init_oe));
		host.finish();
		for (int i = 0; i < INIT_N + 20 && user_mode !== 1'b1; i++) @(negedge clock);
		chk("user_mode", 8'h01, 8'(user_mode));
		chk("init_oe", 8'h00, 8'(init_oe));
		chk("pullup", 8'h00, 8'(weak_pullup_en));
		repeat (2) @(negedge clock);
		chk("pin_oe", 8'(opt), 8'(pin_oe));
		if (opt) chk("pin_out", 8'h01, 8'(pin_out));
		for (int n = 0; n < 16; n++) begin
			rd_addr = 4'(n);
			repeat (2) @(negedge clock);
			chk("image byte", img[n*8+:8], rd_data);
		end
		$display("t_good done");
	endtask
	task t_abort();
		host.start(ok);
		chk("user_mode abort", 8'h00, 8'(user_mode));
		chk("init_oe abort", 8'h01, 8'(init_oe));
		chk("pullup abort", 8'h01, 8'(weak_pullup_en));
		// A neighbour in the chain pulls the shared status line low in load, before any bit is sent.
		ext_status_low = 1'b1;
		repeat (5) @(negedge clock);
		ext_status_low = 1'b0;
		repeat (2) @(negedge clock);
		chk("status chain error", 8'h01, 8'(status_oe));
		chk("complete chain error", 8'h01, 8'(complete_oe));
		$display("t_abort done");
	endtask
	task t_bad();
		load(make_img(8'h33, 1), 0);
		chk("status error", 8'h01, 8'(status_oe));
		chk("complete error", 8'h01, 8'(complete_oe));
		$display("t_bad done");
	endtask
	task tally_and_finish();
		$display("Checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		failures++;
		tally_and_finish();
	end
	initial begin
		rst_b = 1'b0;
		chain_enable_in_n = 1'b0;
		user_data_pin_en = 1'b0;
		user_data_out = 1'b0;
		ext_status_low = 1'b0;
		rd_addr = 4'h0;
		repeat (10) @(negedge clock);
		rst_b = 1'b1;
		repeat (5) @(negedge clock);
		chk("status por", 8'h01, 8'(status_oe));
		chk("complete por", 8'h01, 8'(complete_oe));
		chk("status out", 8'h00, 8'(status_out));
		chk("complete out", 8'h00, 8'(complete_out));
		chk("init out", 8'h00, 8'(init_out));
		$display("t_reset done");
		t_ignore();
		t_good(0);
		t_abort();
		t_bad();
		t_good(1);
		tally_and_finish();
	end
endmodule
